// ==== bench/bmt_bus_peer.sv ====
// Far terminal that answers a command with a status sync after a delay
`timescale 1ns/1ns
`default_nettype none
module bmt_bus_peer (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_arm,
    input wire logic [9:0] i_reply_cyc,
    output logic o_sync
);
    logic [9:0] cnt_q;
    // Zero delay leaves the far terminal silent, as a dead one would be
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_q <= 10'h000;
            o_sync <= 1'b0;
        end else begin
            o_sync <= cnt_q == 10'h001;
            cnt_q <= i_arm ? i_reply_cyc : cnt_q - (cnt_q != 10'h000);
        end
    end
endmodule // bmt_bus_peer
`default_nettype wire

// ==== bench/bmt_timing_chk.sv ====
// Assertion checker on the message timing ports
`timescale 1ns/1ns
`default_nettype none
module bmt_timing_chk (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_clk_12m_sel,
    input wire logic i_bc_start,
    input wire logic i_msg_end,
    input wire logic i_resp_arm,
    input wire logic i_sync_seen,
    input wire logic i_rt_cmd,
    input wire logic o_bc_tx_go,
    input wire logic o_bc_busy,
    input wire logic o_no_resp,
    input wire logic o_rt_status_go
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    // The start and status latency windows below hold for the 16 MHz mode only
    sequence s_req; i_bc_start && !o_bc_busy && !i_clk_12m_sel; endsequence
    a_start_lat: assert property (s_req |-> ##[34:42] o_bc_tx_go) else $error("start late");
    a_start_busy: assert property (s_req |=> o_bc_busy) else $error("not busy");
    a_go_pulse: assert property (o_bc_tx_go |=> !o_bc_tx_go) else $error("go too long");
    a_gap_min: assert property (i_msg_end |=> !o_bc_tx_go [*8]) else $error("gap short");
    a_to_min: assert property (i_resp_arm |=> !o_no_resp [*8]) else $error("timeout early");
    a_sync_cut: assert property (i_sync_seen |=> !o_no_resp) else $error("timeout kept");
    a_rt_lat: assert property (i_rt_cmd && !i_clk_12m_sel |-> ##[98:106] o_rt_status_go)
        else $error("status late");
    a_rt_pulse: assert property (o_rt_status_go |=> !o_rt_status_go) else $error("status long");
endmodule // bmt_timing_chk
bind bmt_timing bmt_timing_chk u_chk (.*);
`default_nettype wire

// ==== bench/bmt_timing_tb.sv ====
// Self-checking bench of the message timing block
`timescale 1ns/1ns
`default_nettype none
`define CHK(s, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("FAIL %s exp %0d got %0d", s, e, g); end end
module bmt_timing_tb;
    logic i_ref_clk = 0, i_arst_n = 0, sel = 0, start = 0, more = 0, mend = 0, arm = 0, cmd = 0, hit;
    logic [15:0] gap = 16'h0000;
    logic [1:0] tsel = 2'h0;
    logic [9:0] reply = 10'h000;
    wire sync, go, busy, nores, stgo;
    int bad_count = 0, checks = 0, n, h;
    int lim[4] = '{37, 45, 101, 256};
    always #50 i_ref_clk = ~i_ref_clk;
    bmt_timing dut_u (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_12m_sel(sel),
        .i_bc_start(start), .i_bc_more(more), .i_msg_end(mend), .i_gap_us(gap),
        .i_timeout_sel(tsel), .i_resp_arm(arm), .i_sync_seen(sync), .i_rt_cmd(cmd),
        .o_bc_tx_go(go), .o_bc_busy(busy), .o_no_resp(nores), .o_rt_status_go(stgo));
    bmt_bus_peer peer_u (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_arm(arm),
        .i_reply_cyc(reply), .o_sync(sync));
    task stop_test;
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Inputs move 10 ns after the edge, clear of sampling
    task e10;
        @(posedge i_ref_clk);
        #10;
    endtask
    // Edges until an output shows; a hang ends the run
    task wt(input int w, input int cap);
        n = 0;
        while (n < cap) begin
            @(posedge i_ref_clk);
            #1 n++;
            if ((w == 0 ? go : w == 1 ? nores : w == 2 ? stgo : !busy) === 1'b1) begin
                #9;
                return;
            end
        end
        bad_count++;
        $display("FAIL wait %0d exp 1 got 0", w);
        stop_test;
    endtask
    task t_start(input logic s);
        sel = s;
        h = s ? 6 : 8;
        e10; // Divider restarts on the mode change before the request
        start = 1;
        e10;
        start = 0;
        wt(0, 400);
        `CHK("start", 1'b1, n >= 4 * h + 2 && n <= 5 * h + 2)
        mend = 1;
        e10;
        mend = 0;
        wt(3, 400);
        `CHK("gap", 1'b1, n >= 20 * h && n <= 21 * h + 2)
        $display("start done");
    endtask
    // Start-to-start of 40 us with a short message
    task t_gap;
        more = 1;
        gap = 16'h0028;
        start = 1;
        e10;
        start = 0;
        wt(0, 400);
        mend = 1;
        e10;
        mend = 0;
        wt(0, 2000);
        `CHK("spacing", 1'b1, n >= 620 && n <= 660)
        // Nothing more queued and no programmed spacing, so the last gap ends
        more = 0;
        gap = 16'h0000;
        mend = 1;
        e10;
        mend = 0;
        wt(3, 400);
        $display("gap done");
    endtask
    task t_to;
        for (int k = 0; k < 4; k++) begin
            tsel = k[1:0];
            arm = 1;
            e10;
            arm = 0;
            wt(1, 2200);
            `CHK("timeout", 1'b1, n >= lim[k] * 8 - 8 && n <= lim[k] * 8 + 9)
        end
        $display("timeout done");
    endtask
    task t_cancel;
        reply = 10'h0c8;
        hit = 0;
        arm = 1;
        e10;
        arm = 0;
        repeat (2200) begin
            @(posedge i_ref_clk);
            #1 hit = hit | nores;
        end
        #9 reply = 10'h000;
        `CHK("cancel", 1'b0, hit)
        $display("cancel done");
    endtask
    task t_rt;
        cmd = 1;
        e10;
        cmd = 0;
        wt(2, 300);
        `CHK("status", 1'b1, n >= 98 && n <= 106)
        $display("status done");
    endtask
    // Main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge i_ref_clk);
        #10 i_arst_n = 1;
        t_start(1);
        t_start(0);
        t_gap;
        t_to;
        t_cancel;
        t_rt;
        stop_test;
    end
endmodule // bmt_timing_tb
`default_nettype wire

// ==== rtl/bmt_tick.v ====
// Half and whole microsecond tick generator for both clock modes
`timescale 1ns/1ns
`default_nettype none
`include "bmt_timing_regs.vh"

module bmt_tick #(
    parameter [7:0] HALF_CYC_16M = `BMT_HALF_US_CYC_16M,
    parameter [7:0] HALF_CYC_12M = `BMT_HALF_US_CYC_12M
) (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire i_clk_12m_sel,
    output reg o_half_tick,
    output reg o_us_tick
);

    reg [7:0] div_q;
    reg sel_q;
    reg phase_q;
    wire [7:0] limit;

    assign limit = i_clk_12m_sel ? HALF_CYC_12M : HALF_CYC_16M;

    // Divider restarts on a mode change so no short tick escapes
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            div_q <= 8'h00;
            sel_q <= 1'b0;
            phase_q <= 1'b0;
            o_half_tick <= 1'b0;
            o_us_tick <= 1'b0;
        end else begin
            sel_q <= i_clk_12m_sel;
            o_half_tick <= 1'b0;
            o_us_tick <= 1'b0;
            if (sel_q != i_clk_12m_sel) begin
                div_q <= 8'h00;
                phase_q <= 1'b0;
            end else if (div_q == limit - 8'h01) begin
                div_q <= 8'h00;
                phase_q <= ~phase_q;
                o_half_tick <= 1'b1;
                o_us_tick <= phase_q;
            end else begin
                div_q <= div_q + 8'h01;
            end
        end
    end

endmodule // bmt_tick
`default_nettype wire

// ==== rtl/bmt_timing.v ====
// Message timing of a dual-redundant serial bus terminal
//
// Three independent timers share one half-microsecond time base:
//   - controller start latency, message and intermessage gap sequencing
//   - no-response timeout, armed at a command's mid-parity crossing
//   - terminal status response delay after a command's mid-parity crossing
//
// Interface notes
//   i_clk_12m_sel   high selects the 12 MHz clock mode, low the 16 MHz mode
//   i_bc_start      host start write done; taken only while the controller is idle
//   i_bc_more       another message is queued; sampled when the gap expires
//   i_msg_end       controller message has left the bus; opens the gap
//   i_gap_us        programmed start-to-start time in microseconds, 0 for default
//   i_timeout_sel   no-response timeout code
//   i_resp_arm      mid-parity of a command; restarts the timeout
//   i_sync_seen     mid-sync of the answering status word; stops the timeout
//   i_rt_cmd        mid-parity of a command this terminal answers
//   o_bc_tx_go      one-cycle pulse, start transmitting a message
//   o_bc_busy       high from start acceptance until the last gap ends
//   o_no_resp       one-cycle pulse, no answer within the selected timeout
//   o_rt_status_go  one-cycle pulse, start the status word
//
// Limitations
//   Every interval uses its typical figure; the half-tick grid adds up to
//   half a microsecond of jitter, which the wide windows of the bus absorb.
//   A start request while busy is dropped with no indication to the host.
//   The clock mode select is a plain level; a change restarts the divider,
//   so one interval running across the change may stretch by a half tick.
//   The 128 us timeout option counts 256 half microseconds.
//   A sync seen in the same cycle as expiry wins, so no false timeout shows.
//
// Reset clears every timer and the divider count; the divider setting follows the clock mode select.
`timescale 1ns/1ns
`default_nettype none
`include "bmt_timing_regs.vh"

module bmt_timing #(
    parameter GAP_W = 16
) (
    input wire i_ref_clk,
    input wire i_arst_n,
    input wire i_clk_12m_sel,
    input wire i_bc_start,
    input wire i_bc_more,
    input wire i_msg_end,
    input wire [GAP_W-1:0] i_gap_us,
    input wire [1:0] i_timeout_sel,
    input wire i_resp_arm,
    input wire i_sync_seen,
    input wire i_rt_cmd,
    output reg o_bc_tx_go,
    output wire o_bc_busy,
    output reg o_no_resp,
    output reg o_rt_status_go
);

    // Controller states
    localparam ST_IDLE = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_MSG = 2'h2;
    localparam ST_GAP = 2'h3;

    // Time base
    wire half_tick;
    wire us_tick;
    // Controller sequencing state
    reg [1:0] st_q;
    reg [8:0] bc_cnt_q;
    reg [GAP_W-1:0] s2s_q;
    // Timeout and status response timers
    reg [8:0] to_cnt_q;
    reg to_run_q;
    reg [8:0] rt_cnt_q;
    reg rt_run_q;
    wire gap_done;

    // Timeout code to half-microsecond count
    function [8:0] to_limit;
        input [1:0] sel;
        begin
            case (sel)
                `BMT_TO_SEL_18P5: to_limit = `BMT_TO_18P5_HALF;
                `BMT_TO_SEL_22P5: to_limit = `BMT_TO_22P5_HALF;
                `BMT_TO_SEL_50P5: to_limit = `BMT_TO_50P5_HALF;
                default: to_limit = `BMT_TO_128_HALF;
            endcase
        end
    endfunction

    // One half-tick step of an interval counter, held when no tick
    function [8:0] half_step;
        input [8:0] cnt;
        input tick;
        begin
            if (tick)
                half_step = cnt + 9'h001;
            else
                half_step = cnt;
        end
    endfunction

    // Tick source follows the clock mode select, whatever its level at reset
    bmt_tick u_tick (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_clk_12m_sel(i_clk_12m_sel),
        .o_half_tick(half_tick),
        .o_us_tick(us_tick)
    );

    // Busy covers start latency, message and gap
    assign o_bc_busy = (st_q != ST_IDLE);

    // Minimum gap and programmed start-to-start time both must pass
    assign gap_done = (bc_cnt_q >= `BMT_GAP_HALF) && (s2s_q >= i_gap_us);

    // Controller sequencing: start latency, message, gap
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_q <= ST_IDLE;
            bc_cnt_q <= 9'h000;
            s2s_q <= {GAP_W{1'b0}};
            o_bc_tx_go <= 1'b0;
        end else begin
            o_bc_tx_go <= 1'b0;
            // Saturating start-to-start count, so a long gap cannot wrap
            if (us_tick && (s2s_q != {GAP_W{1'b1}}))
                s2s_q <= s2s_q + {{(GAP_W-1){1'b0}}, 1'b1};
            case (st_q)
                ST_IDLE: begin
                    bc_cnt_q <= 9'h000;
                    if (i_bc_start)
                        st_q <= ST_START;
                end
                ST_START: begin
                    bc_cnt_q <= half_step(bc_cnt_q, half_tick);
                    if (bc_cnt_q == `BMT_START_HALF) begin
                        o_bc_tx_go <= 1'b1;
                        s2s_q <= {GAP_W{1'b0}};
                        st_q <= ST_MSG;
                    end
                end
                ST_MSG: begin
                    bc_cnt_q <= 9'h000;
                    if (i_msg_end)
                        st_q <= ST_GAP;
                end
                ST_GAP: begin
                    if (half_tick && (bc_cnt_q != 9'h1ff))
                        bc_cnt_q <= bc_cnt_q + 9'h001;
                    if (gap_done) begin
                        bc_cnt_q <= 9'h000;
                        if (i_bc_more) begin
                            o_bc_tx_go <= 1'b1;
                            s2s_q <= {GAP_W{1'b0}};
                            st_q <= ST_MSG;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // No-response timer; a sync in the same cycle as expiry wins
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            to_cnt_q <= 9'h000;
            to_run_q <= 1'b0;
            o_no_resp <= 1'b0;
        end else begin
            o_no_resp <= 1'b0;
            if (i_resp_arm) begin
                to_cnt_q <= 9'h000;
                to_run_q <= 1'b1;
            end else if (to_run_q) begin
                if (i_sync_seen) begin
                    to_run_q <= 1'b0;
                end else if (to_cnt_q == to_limit(i_timeout_sel)) begin
                    to_run_q <= 1'b0;
                    o_no_resp <= 1'b1;
                end else begin
                    to_cnt_q <= half_step(to_cnt_q, half_tick);
                end
            end
        end
    end

    // Terminal status response delay from command mid-parity
    always @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rt_cnt_q <= 9'h000;
            rt_run_q <= 1'b0;
            o_rt_status_go <= 1'b0;
        end else begin
            o_rt_status_go <= 1'b0;
            if (i_rt_cmd) begin
                rt_cnt_q <= 9'h000;
                rt_run_q <= 1'b1;
            end else if (rt_run_q) begin
                if (rt_cnt_q == `BMT_RT_RESP_HALF) begin
                    rt_run_q <= 1'b0;
                    o_rt_status_go <= 1'b1;
                end else begin
                    rt_cnt_q <= half_step(rt_cnt_q, half_tick);
                end
            end
        end
    end

endmodule // bmt_timing
`default_nettype wire

// ==== rtl/bmt_timing_regs.vh ====
// Timing constants of the bus message timing block
`ifndef BMT_TIMING_REGS_VH
`define BMT_TIMING_REGS_VH

// Reference clock cycles per half microsecond in each clock mode
`define BMT_HALF_US_CYC_16M 8'h08
`define BMT_HALF_US_CYC_12M 8'h06

// Intervals in half microseconds
`define BMT_START_HALF 9'h005
`define BMT_GAP_HALF 9'h015
`define BMT_RT_RESP_HALF 9'h00d
`define BMT_TO_18P5_HALF 9'h025
`define BMT_TO_22P5_HALF 9'h02d
`define BMT_TO_50P5_HALF 9'h065
`define BMT_TO_128_HALF 9'h100

// Timeout select codes
`define BMT_TO_SEL_18P5 2'h0
`define BMT_TO_SEL_22P5 2'h1
`define BMT_TO_SEL_50P5 2'h2
`define BMT_TO_SEL_128 2'h3

`endif
